// ---- verilog/sec_pkg.sv ----
// constants, field layout, states and carriers for the sleep, otp and
// security-register command block.
// assumes a 100 MHz core clock; the link clock comes from the host.
package sec_pkg;

  // core clock rate
  localparam int CLK_MHZ = 100;

  // power timing, figures in ns
  localparam int SLEEP_ENTRY_DELAY_NS = 10000;
  localparam int SLEEP_MIN_DWELL_NS = 30000;
  localparam int WAKE_PULSE_WIDTH_NS = 20;
  localparam int WAKE_RECOVERY_DELAY_NS = 30000;

  // cycle counts, least times rounded up, never below one cycle
  localparam int ENTRY_RAW = (SLEEP_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int DWELL_RAW = (SLEEP_MIN_DWELL_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_RAW = (WAKE_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_RAW = (WAKE_RECOVERY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int ENTRY_CYC = (ENTRY_RAW < 1) ? 1 : ENTRY_RAW;
  localparam int DWELL_CYC = (DWELL_RAW < 1) ? 1 : DWELL_RAW;
  localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
  localparam int RECOV_CYC = (RECOV_RAW < 1) ? 1 : RECOV_RAW;

  // opcodes of this block
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h11;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'h12;
  localparam logic [7:0] OP_OTP_ENTER = 8'h13;
  localparam logic [7:0] OP_OTP_EXIT = 8'h14;
  localparam logic [7:0] OP_SEC_READ = 8'h15;
  localparam logic [7:0] OP_SEC_WRITE = 8'h16;

  // opcode length in link clocks
  localparam logic [3:0] SPI_OP_CLKS = 4'h8;
  localparam logic [3:0] QPI_OP_CLKS = 4'h2;

  // security status field positions
  localparam int SEC_PROT_SEL_BIT = 7;
  localparam int SEC_ERASE_FAIL_BIT = 6;
  localparam int SEC_PROG_FAIL_BIT = 5;
  localparam int SEC_RSVD_BIT = 4;
  localparam int SEC_ERASE_SUSP_BIT = 3;
  localparam int SEC_PROG_SUSP_BIT = 2;
  localparam int SEC_LOCKDOWN_BIT = 1;
  localparam int SEC_FACTORY_BIT = 0;
  localparam logic [7:0] SEC_RESET = 8'h00;

  // power states, one-hot
  typedef enum logic [3:0] {
    ST_STANDBY = 4'b0001,
    ST_ENTERING = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKING = 4'b1000
  } power_e;

  // what the link side reports about the last frame
  typedef struct packed {
    logic [7:0] opcode;
    logic op_done;
    logic aligned;
  } frame_s;

  // result and suspend events from the array engine
  typedef struct packed {
    logic erase_done;
    logic erase_ok;
    logic prog_done;
    logic prog_ok;
    logic erase_susp;
    logic erase_resume;
    logic prog_susp;
    logic prog_resume;
  } engine_ev_s;

endpackage : sec_pkg

// ---- verilog/link_shifter.sv ----
// link-side opcode shifter and security-register output shifter.
// runs only on the host's sclk and falling cs_n edges; cs_n high clears frame counters.
`timescale 1ns/1ns
`default_nettype none
module link_shifter
  import sec_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic [3:0] io_in,
  input wire logic qpi_req,
  input wire logic sleep_req,
  input wire logic [7:0] sec_word,
  output frame_s frame,
  output logic frame_tog,
  output logic [3:0] io_out,
  output logic [3:0] io_oe
);

  logic qpi_frame, sleep_s1, sleep_s2;
  logic [3:0] unit_cnt;
  logic [4:0] clk_seen;
  logic [3:0] op_clks;
  logic [2:0] out_idx;
  logic rd_active;

  ////////////////////////////////////////////////////////////////////
  // sleep level from the core clock; sclk may be idle, so it settles
  // over a frame's first two edges, no later than a qpi opcode completes
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
    end else begin
      sleep_s1 <= sleep_req;
      sleep_s2 <= sleep_s1;
    end
  end

  // the mode only changes between frames, so it is caught as cs_n falls;
  // an sclk synchroniser would hold the old mode for a whole qpi opcode
  always_ff @(negedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      qpi_frame <= 1'b0;
    end else begin
      qpi_frame <= qpi_req;
    end
  end

  assign op_clks = qpi_frame ? QPI_OP_CLKS : SPI_OP_CLKS;

  // clocks so far including this one; a fifth bit keeps a saturated
  // count from wrapping to zero and ending a long status read
  assign clk_seen = {1'b0, unit_cnt} + 5'h01;

  // clock count in the frame, cleared while cs_n is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      unit_cnt <= 4'h0;
    end else if (unit_cnt != 4'hF) begin
      unit_cnt <= unit_cnt + 4'h1;
    end
  end

  // opcode capture; upper io lines unused in spi mode
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      frame <= '0;
      frame_tog <= 1'b0;
    end else begin
      if (unit_cnt == 4'h0) begin
        frame_tog <= ~frame_tog;
      end
      if (unit_cnt < op_clks) begin
        if (qpi_frame) begin
          frame.opcode <= {frame.opcode[3:0], io_in};
        end else begin
          frame.opcode <= {frame.opcode[6:0], io_in[0]};
        end
      end
      frame.op_done <= clk_seen >= {1'b0, op_clks};
      // byte boundary: clocks so far a whole multiple of one opcode
      frame.aligned <= (clk_seen % {1'b0, op_clks}) == 5'h00;
    end
  end

  // status read is refused while asleep
  assign rd_active = frame.op_done && !sleep_s2 &&
    frame.opcode == OP_SEC_READ;

  // security word out on falling edges, repeating while cs_n low
  always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n) begin
      out_idx <= 3'h0;
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (rd_active) begin
      if (qpi_frame) begin
        io_out <= out_idx[2] ? sec_word[3:0] : sec_word[7:4];
        io_oe <= 4'hF;
        out_idx <= out_idx + 3'h4;
      end else begin
        io_out <= {2'b00, sec_word[3'h7 - out_idx], 1'b0};
        io_oe <= 4'h2;
        out_idx <= out_idx + 3'h1;
      end
    end
  end

endmodule : link_shifter
`default_nettype wire

// ---- verilog/powerdown_otp_security.sv ----
// core of the deep-sleep, secured-otp and security-register commands.
// assumes a 100 MHz clk, a host-driven sclk and cs_n, and an array
// engine on clk reporting results as single-cycle events.
`timescale 1ns/1ns
`default_nettype none
module powerdown_otp_security
  import sec_pkg::*;
#(
  parameter int TMR_W = 12
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic qpi_mode,
  input wire engine_ev_s engine_ev,
  input wire logic wel_clear,
  input wire logic protect_sel_set,
  input wire logic nv_protect_sel,
  input wire logic nv_lockdown,
  input wire logic nv_factory_lock,
  output logic [7:0] sec_status,
  output logic write_enable_latch,
  output logic otp_mode,
  output logic main_array_allow,
  output logic otp_program_allow,
  output logic lockdown_store,
  output logic deep_sleep,
  output logic dwell_done,
  output logic other_cmd_valid,
  output logic [7:0] other_opcode
);

  ////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (ENTRY_CYC >= (1 << TMR_W) || DWELL_CYC >= (1 << TMR_W) ||
      PULSE_CYC >= (1 << TMR_W) || RECOV_CYC >= (1 << TMR_W)) begin : g_chk
    $error("timer width too small for the power timing counts");
  end

  localparam logic [TMR_W-1:0] ENTRY_T = TMR_W'(ENTRY_CYC);
  localparam logic [TMR_W-1:0] DWELL_T = TMR_W'(DWELL_CYC);
  localparam logic [TMR_W-1:0] PULSE_T = TMR_W'(PULSE_CYC);
  localparam logic [TMR_W-1:0] RECOV_T = TMR_W'(RECOV_CYC);

  ////////////////////////////////////////////////////////////////////
  // declarations

  frame_s frame_link;
  frame_s frame_reg;
  logic frame_tog;
  logic cs_s1, cs_s2, cs_d;
  logic tog_s1, tog_s2, tog_seen;
  logic cs_rise;
  logic cmd_go;
  logic [TMR_W-1:0] low_cnt;
  logic [TMR_W-1:0] tmr_reg;
  power_e state_reg, state_next;
  logic wake_hit;
  logic loaded_reg;
  logic prot_sel_reg, lockdown_reg, factory_reg;
  logic erase_fail_reg, prog_fail_reg;
  logic erase_susp_reg, prog_susp_reg;
  logic wel_reg, otp_reg;
  logic [7:0] sec_live;
  logic [7:0] sec_snap_reg;
  logic sleep_level;

  // decode of an accepted opcode, used by several processes
  function automatic logic is_op(input frame_s f, input logic [7:0] op);
    is_op = f.op_done && f.opcode == op;
  endfunction : is_op

  ////////////////////////////////////////////////////////////////////
  // link side, on the host's clock

  link_shifter u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .rst_n(rst_n),
    .io_in(io_in),
    .qpi_req(qpi_mode),
    .sleep_req(sleep_level),
    .sec_word(sec_snap_reg),
    .frame(frame_link),
    .frame_tog(frame_tog),
    .io_out(io_out),
    .io_oe(io_oe)
  );

  ////////////////////////////////////////////////////////////////////
  // crossings from the link: cs_n level and frame toggle

  // the first stage feeds only the second; edges use the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
    end
  end

  assign cs_rise = cs_s2 && !cs_d;

  // frame word is stable once cs_n is high, since sclk is idle then;
  // a frame with no clocks leaves the toggle alone and is no command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= '0;
      tog_seen <= 1'b0;
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= 1'b0;
      if (cs_rise) begin
        frame_reg <= frame_link;
        tog_seen <= tog_s2;
        cmd_go <= tog_s2 != tog_seen;
      end
    end
  end

  // width of the current cs_n low pulse, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
    end else if (cs_s2) begin
      low_cnt <= low_cnt;
      if (cs_d) begin
        low_cnt <= '0;
      end
    end else if (low_cnt != PULSE_T) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // a wide enough low pulse ends the sleep
  assign wake_hit = cs_rise && low_cnt >= PULSE_T;

  ////////////////////////////////////////////////////////////////////
  // power state machine

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: begin
        if (cmd_go && frame_reg.aligned &&
            is_op(frame_reg, OP_DEEP_SLEEP)) begin
          state_next = ST_ENTERING;
        end
      end
      ST_ENTERING: begin
        if (tmr_reg == ENTRY_T - 1'b1) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_next = ST_WAKING;
        end
      end
      ST_WAKING: begin
        if (tmr_reg == RECOV_T - 1'b1) begin
          state_next = ST_STANDBY;
        end
      end
      default: state_next = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // one timer serves entry, dwell and recovery; restarts on change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_reg <= '0;
    end else if (state_next != state_reg) begin
      tmr_reg <= '0;
    end else if (tmr_reg != {TMR_W{1'b1}}) begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  // dwell is the host's to respect; shown here so it can be watched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwell_done <= 1'b0;
    end else begin
      dwell_done <= state_reg == ST_SLEEP && tmr_reg >= DWELL_T;
    end
  end

  assign sleep_level = state_reg == ST_SLEEP || state_reg == ST_WAKING;
  assign deep_sleep = state_reg == ST_SLEEP;

  ////////////////////////////////////////////////////////////////////
  // non-volatile bits, caught once after reset release

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_reg <= 1'b0;
      prot_sel_reg <= 1'b0;
      lockdown_reg <= 1'b0;
      factory_reg <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      prot_sel_reg <= nv_protect_sel;
      lockdown_reg <= nv_lockdown;
      factory_reg <= nv_factory_lock;
    end else begin
      if (protect_sel_set) begin
        prot_sel_reg <= 1'b1;
      end
      if (lockdown_store) begin
        lockdown_reg <= 1'b1;
      end
    end
  end

  // lockdown write: latch set, byte boundary, not already locked
  assign lockdown_store = cmd_go && state_reg == ST_STANDBY &&
    frame_reg.aligned && wel_reg && !lockdown_reg &&
    is_op(frame_reg, OP_SEC_WRITE);

  ////////////////////////////////////////////////////////////////////
  // volatile result and suspend flags; they never stall the engine

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_fail_reg <= 1'b0;
      prog_fail_reg <= 1'b0;
    end else begin
      if (engine_ev.erase_done) begin
        erase_fail_reg <= !engine_ev.erase_ok;
      end
      if (engine_ev.prog_done) begin
        prog_fail_reg <= !engine_ev.prog_ok;
      end
    end
  end

  // a suspend in the same cycle as a resume wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_susp_reg <= 1'b0;
      prog_susp_reg <= 1'b0;
    end else begin
      if (engine_ev.erase_susp) begin
        erase_susp_reg <= 1'b1;
      end else if (engine_ev.erase_resume) begin
        erase_susp_reg <= 1'b0;
      end
      if (engine_ev.prog_susp) begin
        prog_susp_reg <= 1'b1;
      end else if (engine_ev.prog_resume) begin
        prog_susp_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write enable latch and otp mode

  // set wins over an outside clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (cmd_go && state_reg == ST_STANDBY &&
                 is_op(frame_reg, OP_WRITE_ENABLE)) begin
      wel_reg <= 1'b1;
    end else if (wel_clear || lockdown_store) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_reg <= 1'b0;
    end else if (cmd_go && state_reg == ST_STANDBY) begin
      if (is_op(frame_reg, OP_OTP_ENTER)) begin
        otp_reg <= 1'b1;
      end else if (is_op(frame_reg, OP_OTP_EXIT)) begin
        otp_reg <= 1'b0;
      end
    end
  end

  assign write_enable_latch = wel_reg;
  assign otp_mode = otp_reg;
  assign main_array_allow = !otp_reg;
  assign otp_program_allow = otp_reg && !lockdown_reg;

  ////////////////////////////////////////////////////////////////////
  // all other whole opcodes seen in standby go on to the rest of the device

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      other_cmd_valid <= 1'b0;
      other_opcode <= 8'h00;
    end else begin
      other_cmd_valid <= 1'b0;
      if (cmd_go && state_reg == ST_STANDBY &&
          frame_reg.op_done &&
          frame_reg.opcode != OP_WRITE_ENABLE &&
          frame_reg.opcode != OP_DEEP_SLEEP &&
          frame_reg.opcode != OP_OTP_ENTER &&
          frame_reg.opcode != OP_OTP_EXIT &&
          frame_reg.opcode != OP_SEC_READ &&
          frame_reg.opcode != OP_SEC_WRITE) begin
        other_cmd_valid <= 1'b1;
        other_opcode <= frame_reg.opcode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // security status word

  always_comb begin
    sec_live = SEC_RESET;
    sec_live[SEC_PROT_SEL_BIT] = prot_sel_reg;
    sec_live[SEC_ERASE_FAIL_BIT] = erase_fail_reg;
    sec_live[SEC_PROG_FAIL_BIT] = prog_fail_reg;
    sec_live[SEC_RSVD_BIT] = 1'b0;
    sec_live[SEC_ERASE_SUSP_BIT] = erase_susp_reg;
    sec_live[SEC_PROG_SUSP_BIT] = prog_susp_reg;
    sec_live[SEC_LOCKDOWN_BIT] = lockdown_reg;
    sec_live[SEC_FACTORY_BIT] = factory_reg;
  end

  // frozen while cs_n is low so the link shifts a steady word;
  // a change during a read shows at the next frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_snap_reg <= SEC_RESET;
      sec_status <= SEC_RESET;
    end else begin
      sec_status <= sec_live;
      if (cs_s2) begin
        sec_snap_reg <= sec_live;
      end
    end
  end

endmodule : powerdown_otp_security
`default_nettype wire

// ---- tb/host_model.sv ----
// host controller model: frames opcodes on cs_n, sclk and io_in.
// assumes the block samples on rising sclk and drives on falling sclk.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic qpi,
  input wire logic [3:0] io_out,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_in
);
  logic [15:0] rd_bits;

  // sclk stands still and cs_n is high outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'hA;
    rd_bits = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // opcode clocks then read clocks; the 3 ns lead keeps edges off clk
  task automatic frame(input logic [7:0] op, input int n_clk,
                       input int n_rd);
    logic [7:0] sh;
    sh = op;
    #3 cs_n = 1'b0;
    #15;
    for (int i = 0; i < n_clk + n_rd; i++) begin
      if (qpi) begin
        io_in = sh[7:4];
        sh = {sh[3:0], 4'h0};
      end else begin
        // upper lines toggle so they cannot pass for a settled value
        io_in = {~io_in[3:1], sh[7]};
        sh = {sh[6:0], 1'b0};
      end
      #15 sclk = 1'b1;
      if (i >= n_clk) rd_bits = {rd_bits[14:0], io_out[1]};
      #15 sclk = 1'b0;
    end
    #15 cs_n = 1'b1;
    io_in = ~io_in;
    #150;
  endtask : frame

  // low pulse of 30 ns with no sclk edges
  task automatic wake();
    #3 cs_n = 1'b0;
    #30 cs_n = 1'b1;
    #100;
  endtask : wake
endmodule : host_model
`default_nettype wire

// ---- tb/sec_chk.sv ----
// port assertions for the sleep, otp and security register block.
// assumes clk is the core clock and rst_n its async reset.
`timescale 1ns/1ns
`default_nettype none
module sec_chk
  import sec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire engine_ev_s engine_ev,
  input wire logic [3:0] io_oe,
  input wire logic [7:0] sec_status,
  input wire logic write_enable_latch,
  input wire logic otp_mode,
  input wire logic main_array_allow,
  input wire logic otp_program_allow,
  input wire logic lockdown_store,
  input wire logic deep_sleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // status word lags its cause by two edges
  property p_main; main_array_allow == !otp_mode; endproperty
  a_main: assert property (p_main) else $error("main array open");
  property p_prog; sec_status[1] |-> !otp_program_allow; endproperty
  a_prog: assert property (p_prog) else $error("otp program open");
  property p_lock; sec_status[1] |=> sec_status[1]; endproperty
  a_lock: assert property (p_lock) else $error("lockdown lost");
  property p_store; lockdown_store |-> write_enable_latch ##2 sec_status[1]; endproperty
  a_store: assert property (p_store) else $error("bad write");
  property p_prot; sec_status[7] |=> sec_status[7]; endproperty
  a_prot: assert property (p_prot) else $error("protect lost");
  property p_rsvd; sec_status[4] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_efail;
    engine_ev.erase_done && !engine_ev.erase_ok |-> ##2 sec_status[6];
  endproperty
  a_efail: assert property (p_efail) else $error("erase fail");
  property p_pok;
    engine_ev.prog_done && engine_ev.prog_ok |-> ##2 !sec_status[5];
  endproperty
  a_pok: assert property (p_pok) else $error("program fail");
  property p_esusp; engine_ev.erase_susp |-> ##2 sec_status[3]; endproperty
  a_esusp: assert property (p_esusp) else $error("erase susp");
  property p_pres;
    engine_ev.prog_resume && !engine_ev.prog_susp |-> ##2 !sec_status[2];
  endproperty
  a_pres: assert property (p_pres) else $error("prog resume");
  property p_quiet; deep_sleep |-> io_oe == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("output in sleep");

  c_store: cover property (lockdown_store);
  c_sleep: cover property ($rose(deep_sleep));
  c_otp: cover property ($rose(otp_mode));
endmodule : sec_chk

bind powerdown_otp_security sec_chk u_sec_chk (
  .clk(clk), .rst_n(rst_n), .engine_ev(engine_ev), .io_oe(io_oe),
  .sec_status(sec_status), .write_enable_latch(write_enable_latch), .otp_mode(otp_mode),
  .main_array_allow(main_array_allow),
  .otp_program_allow(otp_program_allow),
  .lockdown_store(lockdown_store), .deep_sleep(deep_sleep)
);
`default_nettype wire

// ---- tb/powerdown_otp_security_tb_top.sv ----
// self-checking bench: host model on the link, events on the core side.
// assumes the package timing counts and a 100 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
module powerdown_otp_security_tb_top
  import sec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qpi_mode = 1'b0;
  logic protect_sel_set = 1'b0;
  engine_ev_s engine_ev = '0;
  logic cs_n, sclk, write_enable_latch, otp_mode, main_array_allow, otp_program_allow;
  logic lockdown_store, deep_sleep, dwell_done, other_cmd_valid;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] sec_status, other_opcode;
  int n_mismatch = 0;
  int checks = 0;
  int n_other = 0;

  always #5 clk = ~clk;

  // passed-on commands, counted off the launching edge
  always @(negedge clk) begin
    if (other_cmd_valid === 1'b1) n_other++;
  end

  // stored bits tied: factory lock set, the rest clear
  powerdown_otp_security u_powerdown_otp_security (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .qpi_mode(qpi_mode),
    .engine_ev(engine_ev), .wel_clear(1'b0),
    .protect_sel_set(protect_sel_set), .nv_protect_sel(1'b0),
    .nv_lockdown(1'b0), .nv_factory_lock(1'b1), .sec_status(sec_status),
    .write_enable_latch(write_enable_latch), .otp_mode(otp_mode), .main_array_allow(main_array_allow),
    .otp_program_allow(otp_program_allow),
    .lockdown_store(lockdown_store), .deep_sleep(deep_sleep),
    .dwell_done(dwell_done), .other_cmd_valid(other_cmd_valid),
    .other_opcode(other_opcode)
  );
  host_model u_host_model (
    .qpi(qpi_mode), .io_out(io_out), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // a frame, then back onto the falling clk edge
  task automatic op(input logic [7:0] code, input int n, input int rd);
    u_host_model.frame(code, n, rd);
    @(negedge clk);
  endtask : op

  task automatic pulse_ev(input engine_ev_s e);
    @(negedge clk) engine_ev = e;
    @(negedge clk) engine_ev = '0;
    repeat (3) @(negedge clk);
  endtask : pulse_ev

  ////////////////////////////////////////////////////////////////////////
  task automatic t_read(input logic [7:0] exp);
    op(OP_SEC_READ, 8, 16);
    check("read_first", u_host_model.rd_bits[15:8], exp);
    check("read_again", u_host_model.rd_bits[7:0], exp);
  endtask : t_read

  // both failures and both suspends land in the same cycle
  task automatic t_events();
    pulse_ev(engine_ev_s'(8'hAA));
    check("fail_susp", sec_status, 8'h6D);
    check("erase_susp", sec_status[3], 1'b1);
    check("prog_susp", sec_status[2], 1'b1);
    @(negedge clk) protect_sel_set = 1'b1;
    @(negedge clk) protect_sel_set = 1'b0;
    repeat (3) @(negedge clk);
    check("prot_sel", sec_status, 8'hED);
    t_read(8'hED);
    pulse_ev(engine_ev_s'(8'hF5));
    check("ok_resume", sec_status, 8'h81);
  endtask : t_events

  // lockdown written from inside otp mode, refused twice first
  task automatic t_otp();
    op(OP_OTP_ENTER, 8, 0);
    check("otp_mode", otp_mode, 1'b1);
    check("main_allow", main_array_allow, 1'b0);
    check("otp_prog", otp_program_allow, 1'b1);
    op(OP_SEC_WRITE, 8, 0);
    check("lock_no_wel", sec_status[1], 1'b0);
    op(OP_WRITE_ENABLE, 8, 0);
    check("wel", write_enable_latch, 1'b1);
    op(OP_SEC_WRITE, 9, 0);
    check("lock_unaligned", sec_status[1], 1'b0);
    op(OP_SEC_WRITE, 8, 0);
    check("lock", sec_status[1], 1'b1);
    check("wel_used", write_enable_latch, 1'b0);
    check("otp_locked", otp_program_allow, 1'b0);
    op(OP_OTP_EXIT, 8, 0);
    check("otp_exit", main_array_allow, 1'b1);
  endtask : t_otp

  task automatic t_other();
    op(8'hA5, 8, 0);
    check("spi_opcode", other_opcode, 8'hA5);
    qpi_mode = 1'b1;
    op(8'h5A, 2, 0);
    check("qpi_opcode", other_opcode, 8'h5A);
    check("other_seen", n_other[7:0], 8'h02);
    qpi_mode = 1'b0;
  endtask : t_other

  // the host keeps cs_n high until the minimum dwell has run out
  task automatic t_dwell();
    for (int i = 0; i < DWELL_CYC + 100 && dwell_done !== 1'b1; i++)
      @(negedge clk);
    check("dwell", dwell_done, 1'b1);
  endtask : t_dwell

  task automatic t_sleep();
    op(OP_DEEP_SLEEP, 7, 0);
    repeat (ENTRY_CYC + 20) @(negedge clk);
    check("sleep_short", deep_sleep, 1'b0);
    qpi_mode = 1'b1;
    op(OP_DEEP_SLEEP, 2, 0);
    repeat (ENTRY_CYC - 30) @(negedge clk);
    check("sleep_early", deep_sleep, 1'b0);
    repeat (40) @(negedge clk);
    check("sleep", deep_sleep, 1'b1);
    check("dwell_early", dwell_done, 1'b0);
    t_dwell();
    // an ignored frame is still a cs_n low pulse long enough to wake
    op(OP_OTP_ENTER, 2, 0);
    check("sleep_ignores", otp_mode, 1'b0);
    check("frame_wakes", deep_sleep, 1'b0);
    repeat (RECOV_CYC + 50) @(negedge clk);
    qpi_mode = 1'b0;
    op(OP_DEEP_SLEEP, 8, 0);
    repeat (ENTRY_CYC + 20) @(negedge clk);
    t_dwell();
    check("asleep", deep_sleep, 1'b1);
    u_host_model.wake();
    @(negedge clk);
    check("woken", deep_sleep, 1'b0);
    repeat (RECOV_CYC + 50) @(negedge clk);
    t_read(8'h83);
  endtask : t_sleep

  // main sequence; reset held for three cycles
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("reset_status", sec_status, 8'h01 << SEC_FACTORY_BIT);
    check("reset_main", main_array_allow, 1'b1);
    t_read(8'h01);
    t_events();
    t_otp();
    t_other();
    t_sleep();
    wrap_up();
  end

  // the run needs about 15000 cycles
  initial begin
    #300000;
    n_mismatch++;
    wrap_up();
  end
endmodule : powerdown_otp_security_tb_top
`default_nettype wire
